/* core/fps_pkg.sv */
// Constants, opcode patterns, register map and carrier types for the
// flag, port-status and serial opcode decoder.
// Assumes one 100 MHz system clock shared by all users of the package.
package fps_pkg;

  // ==========================================================
  // Opcode patterns: an opcode matches when (op & mask) == value
  localparam logic [15:0] M_ADDR7 = 16'hFF80;
  localparam logic [15:0] M_IMM8 = 16'hFF00;
  localparam logic [15:0] M_FULL = 16'hFFFF;
  localparam logic [15:0] M_IMM4 = 16'hFFF0;
  localparam logic [15:0] M_IMM1 = 16'hFFFE;
  localparam logic [15:0] M_IMM2 = 16'hFFF3;
  localparam logic [15:0] OPC_EVF_LO = 16'h5D00;
  localparam logic [15:0] OPC_EVF_HI = 16'h5D80;
  localparam logic [15:0] OPC_HEF = 16'h4100;
  localparam logic [15:0] OPC_HOLD_RELEASE_ENABLE_PORT2 = 16'h3100;
  localparam logic [15:0] OPC_IEF = 16'h5100;
  localparam logic [15:0] OPC_PEF = 16'h4300;
  localparam logic [15:0] OPC_SECONDARY_PORT_ENABLES = 16'h3300;
  localparam logic [15:0] OPC_SEF = 16'h5200;
  localparam logic [15:0] OPC_PSR_RD0 = 16'h4F00;
  localparam logic [15:0] OPC_PSR_RD1 = 16'h4F80;
  localparam logic [15:0] OPC_PSR_RD2 = 16'h5F00;
  localparam logic [15:0] OPC_PSR_CLR0 = 16'h4200;
  localparam logic [15:0] OPC_PSR_CLR1 = 16'h4280;
  localparam logic [15:0] OPC_PSR_CLR2 = 16'h42C0;
  localparam logic [15:0] OPC_DIV_CLR0 = 16'h1700;
  localparam logic [15:0] OPC_DIV_CLR1 = 16'h5580;
  localparam logic [15:0] OPC_SOP = 16'hAF00;
  localparam logic [15:0] OPC_SIP = 16'h9F00;

  // ==========================================================
  // Decoded operation
  typedef enum {
    OP_NONE, OP_EVF_LO, OP_EVF_HI, OP_HEF, OP_HOLD_RELEASE_ENABLE_PORT2, OP_IEF, OP_PEF, OP_SECONDARY_PORT_ENABLES,
    OP_SEF, OP_PSR_RD0, OP_PSR_RD1, OP_PSR_RD2, OP_PSR_CLR0, OP_PSR_CLR1,
    OP_PSR_CLR2, OP_DIV_CLR0, OP_DIV_CLR1, OP_SOP, OP_SIP
  } fps_op_t;

  // ==========================================================
  // Enable flag groups, carried together
  typedef struct packed {
    logic [7:0] hold_release_enables;
    logic hold_release_enable_port2;
    logic [7:0] interrupt_enables;
    logic [3:0] port_enables;
    logic [1:0] secondary_port_enables;
    logic [7:0] stop_wake_enables;
  } fps_enables_t;

  localparam fps_enables_t ENABLES_RST = '0;

  // ==========================================================
  // Widths, reset values, timing
  localparam int DIV_WIDTH = 15;
  localparam logic [3:0] DIV_LOW_CLEAR = 4'h0;
  localparam logic [11:0] PSR_RST = 12'h000;
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam int CLK_MHZ = 100;
  localparam int SER_BIT_NS = 100;
  localparam int SER_BIT_CYCLES = (SER_BIT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] SER_LAST_BIT = 3'h7;

  // ==========================================================
  // AXI4-Lite register map (byte addresses)
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0C;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int EVT_SOP_DONE = 0;
  localparam int EVT_SIP_DONE = 1;
  localparam int EVT_PORT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fps_pkg

/* core/fps_serial_shifter.sv */
// Eight-bit serial shifter on one two-way port pin, MSB first.
// Assumes pin input is synchronous to the system clock.
`timescale 1ns/1ps
module fps_serial_shifter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic dir_in_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rx_byte_o
);

  localparam logic [3:0] TICK_LAST = 4'(fps_pkg::SER_BIT_CYCLES - 1);

  logic [7:0] sh;
  logic [2:0] bit_cnt;
  logic [3:0] tick;
  logic dir_in;
  logic bit_end;

  assign bit_end = busy_o && (tick == TICK_LAST);
  assign pin_o = sh[7];
  // Drive only while shifting out; shift in leaves the pin to the far end
  assign pin_oe_o = busy_o && !dir_in;

  // ==========================================================
  // Bit timing and shift register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      sh <= 8'h00;
      bit_cnt <= 3'h0;
      tick <= 4'h0;
      dir_in <= 1'b0;
    end else if (start_i && !busy_o) begin
      busy_o <= 1'b1;
      sh <= dir_in_i ? 8'h00 : tx_byte_i;
      bit_cnt <= 3'h0;
      tick <= 4'h0;
      dir_in <= dir_in_i;
    end else if (bit_end) begin
      tick <= 4'h0;
      sh <= {sh[6:0], dir_in ? pin_i : 1'b0}; // Sample at end of bit
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == fps_pkg::SER_LAST_BIT) begin
        busy_o <= 1'b0;
      end
    end else if (busy_o) begin
      tick <= tick + 4'h1;
    end
  end

  // ==========================================================
  // Completion pulse and captured byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      rx_byte_o <= 8'h00;
    end else begin
      done_o <= bit_end && (bit_cnt == fps_pkg::SER_LAST_BIT);
      if (bit_end && (bit_cnt == fps_pkg::SER_LAST_BIT)) begin
        rx_byte_o <= {sh[6:0], pin_i};
      end
    end
  end

endmodule : fps_serial_shifter

/* core/fps_flag_port_decoder.sv */
// Decoder and executor for the flag, enable, port-status, divider and
// serial opcodes of a 4-bit core, with an AXI4-Lite control slave.
// Assumes data memory is read combinationally at RAM_RADDR_O.
`timescale 1ns/1ps

module fps_flag_port_decoder (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [15:0] OPCODE_I,
  input wire logic OPCODE_VALID_I,
  output logic OPCODE_READY_O,
  input wire logic [7:0] EVENT_FLAGS_I,
  input wire logic [11:0] PORT_EVENT_I,
  output logic [6:0] RAM_RADDR_O,
  input wire logic [3:0] RAM_RDATA_I,
  output logic RAM_WE_O,
  output logic [6:0] RAM_WADDR_O,
  output logic [3:0] RAM_WDATA_O,
  output logic [3:0] ACC_O,
  output logic ZERO_FLAG_O,
  output fps_pkg::fps_enables_t ENABLES_O,
  output logic [11:0] PORT_STATUS_O,
  output logic [fps_pkg::DIV_WIDTH-1:0] DIV0_O,
  output logic [fps_pkg::DIV_WIDTH-1:0] DIV1_O,
  input wire logic SER_PIN_I,
  output logic SER_PIN_O,
  output logic SER_PIN_OE_O,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic IRQ_O
);

  // ==========================================================
  // Opcode decode, shared by execution and checks
  function automatic fps_pkg::fps_op_t fps_decode(input logic [15:0] op);
    if ((op & fps_pkg::M_ADDR7) == fps_pkg::OPC_EVF_LO) return fps_pkg::OP_EVF_LO;
    if ((op & fps_pkg::M_ADDR7) == fps_pkg::OPC_EVF_HI) return fps_pkg::OP_EVF_HI;
    if ((op & fps_pkg::M_IMM8) == fps_pkg::OPC_HEF) return fps_pkg::OP_HEF;
    if ((op & fps_pkg::M_IMM1) == fps_pkg::OPC_HOLD_RELEASE_ENABLE_PORT2) return fps_pkg::OP_HOLD_RELEASE_ENABLE_PORT2;
    if ((op & fps_pkg::M_IMM8) == fps_pkg::OPC_IEF) return fps_pkg::OP_IEF;
    if ((op & fps_pkg::M_IMM4) == fps_pkg::OPC_PEF) return fps_pkg::OP_PEF;
    if ((op & fps_pkg::M_IMM2) == fps_pkg::OPC_SECONDARY_PORT_ENABLES) return fps_pkg::OP_SECONDARY_PORT_ENABLES;
    if ((op & fps_pkg::M_IMM8) == fps_pkg::OPC_SEF) return fps_pkg::OP_SEF;
    if ((op & fps_pkg::M_ADDR7) == fps_pkg::OPC_PSR_RD0) return fps_pkg::OP_PSR_RD0;
    if ((op & fps_pkg::M_ADDR7) == fps_pkg::OPC_PSR_RD1) return fps_pkg::OP_PSR_RD1;
    if ((op & fps_pkg::M_ADDR7) == fps_pkg::OPC_PSR_RD2) return fps_pkg::OP_PSR_RD2;
    if (op == fps_pkg::OPC_PSR_CLR0) return fps_pkg::OP_PSR_CLR0;
    if (op == fps_pkg::OPC_PSR_CLR1) return fps_pkg::OP_PSR_CLR1;
    if (op == fps_pkg::OPC_PSR_CLR2) return fps_pkg::OP_PSR_CLR2;
    if (op == fps_pkg::OPC_DIV_CLR0) return fps_pkg::OP_DIV_CLR0;
    if (op == fps_pkg::OPC_DIV_CLR1) return fps_pkg::OP_DIV_CLR1;
    if ((op & fps_pkg::M_ADDR7) == fps_pkg::OPC_SOP) return fps_pkg::OP_SOP;
    if ((op & fps_pkg::M_ADDR7) == fps_pkg::OPC_SIP) return fps_pkg::OP_SIP;
    return fps_pkg::OP_NONE;
  endfunction : fps_decode

  // Mapped register check, used by both bus directions
  function automatic logic fps_mapped(input logic [7:0] a);
    return (a == fps_pkg::REG_STATUS) || (a == fps_pkg::REG_MASK) ||
           (a == fps_pkg::REG_CTRL) || (a == fps_pkg::REG_STATE);
  endfunction : fps_mapped

  fps_pkg::fps_op_t op;
  logic take;
  logic ctrl_en;
  logic ser_busy;
  logic ser_done;
  logic ser_is_in;
  logic [6:0] ser_addr;
  logic [7:0] ser_rx;
  logic [3:0] psr [3];
  logic [2:0] psr_clr;
  logic [1:0] div_clr;
  logic [fps_pkg::DIV_WIDTH-1:0] div [2];
  logic ld;
  logic [3:0] next_acc;

  assign op = fps_decode(OPCODE_I);
  // New opcodes wait while a serial transfer runs or software halts decode.
  // Also held off in the done cycle, so a load cannot overwrite the shift-in result.
  assign OPCODE_READY_O = ctrl_en && !ser_busy && !ser_done;
  assign take = OPCODE_VALID_I && OPCODE_READY_O;
  assign RAM_RADDR_O = OPCODE_I[6:0];
  assign PORT_STATUS_O = {psr[2], psr[1], psr[0]};
  assign DIV0_O = div[0];
  assign DIV1_O = div[1];

  // ==========================================================
  // Result nibble for accumulator-and-R loads
  always_comb begin
    ld = 1'b0;
    next_acc = fps_pkg::ACC_RST;
    unique case (op)
      fps_pkg::OP_EVF_LO: begin
        ld = 1'b1;
        next_acc = EVENT_FLAGS_I[3:0];
      end
      fps_pkg::OP_EVF_HI: begin
        ld = 1'b1;
        next_acc = EVENT_FLAGS_I[7:4];
      end
      fps_pkg::OP_PSR_RD0: begin
        ld = 1'b1;
        next_acc = psr[0];
      end
      fps_pkg::OP_PSR_RD1: begin
        ld = 1'b1;
        next_acc = psr[1];
      end
      fps_pkg::OP_PSR_RD2: begin
        ld = 1'b1;
        next_acc = psr[2];
      end
      default: begin
        ld = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Accumulator and zero flag; untouched by every other opcode except SIP, whose completion loads the low received nibble
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      ACC_O <= fps_pkg::ACC_RST;
      ZERO_FLAG_O <= 1'b1;
    end else if (take && ld) begin
      ACC_O <= next_acc;
      ZERO_FLAG_O <= (next_acc == 4'h0);
    end else if (ser_done && ser_is_in) begin
      ACC_O <= ser_rx[3:0];
      ZERO_FLAG_O <= (ser_rx[3:0] == 4'h0);
    end
  end

  // ==========================================================
  // Data memory write port, one cycle after the cause
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      RAM_WE_O <= 1'b0;
      RAM_WADDR_O <= 7'h00;
      RAM_WDATA_O <= 4'h0;
    end else begin
      RAM_WE_O <= (take && ld) || (ser_done && ser_is_in);
      if (take && ld) begin
        RAM_WADDR_O <= OPCODE_I[6:0];
        RAM_WDATA_O <= next_acc;
      end else if (ser_done && ser_is_in) begin
        RAM_WADDR_O <= ser_addr;
        RAM_WDATA_O <= ser_rx[7:4];
      end
    end
  end

  // ==========================================================
  // Enable flag groups
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      ENABLES_O <= fps_pkg::ENABLES_RST;
    end else if (take) begin
      unique case (op)
        fps_pkg::OP_HEF: ENABLES_O.hold_release_enables <= OPCODE_I[7:0];
        fps_pkg::OP_HOLD_RELEASE_ENABLE_PORT2: ENABLES_O.hold_release_enable_port2 <= OPCODE_I[0];
        fps_pkg::OP_IEF: ENABLES_O.interrupt_enables <= OPCODE_I[7:0];
        fps_pkg::OP_PEF: ENABLES_O.port_enables <= OPCODE_I[3:0];
        fps_pkg::OP_SECONDARY_PORT_ENABLES: ENABLES_O.secondary_port_enables <= OPCODE_I[3:2];
        fps_pkg::OP_SEF: ENABLES_O.stop_wake_enables <= OPCODE_I[7:0];
        default: ENABLES_O <= ENABLES_O;
      endcase
    end
  end

  // ==========================================================
  // Port status registers and dividers
  assign psr_clr[0] = take && (op == fps_pkg::OP_PSR_CLR0);
  assign psr_clr[1] = take && (op == fps_pkg::OP_PSR_CLR1);
  assign psr_clr[2] = take && (op == fps_pkg::OP_PSR_CLR2);
  assign div_clr[0] = take && (op == fps_pkg::OP_DIV_CLR0);
  assign div_clr[1] = take && (op == fps_pkg::OP_DIV_CLR1);

  generate
    for (genvar k = 0; k < 3; k++) begin : g_psr
      // A port event in the clearing cycle survives: set wins over clear
      always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
          psr[k] <= fps_pkg::PSR_RST[4*k +: 4];
        end else if (psr_clr[k]) begin
          psr[k] <= PORT_EVENT_I[4*k +: 4];
        end else begin
          psr[k] <= psr[k] | PORT_EVENT_I[4*k +: 4];
        end
      end
    end
    for (genvar d = 0; d < 2; d++) begin : g_div
      // Free running; a clear zeroes only the four lowest stages
      always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
          div[d] <= '0;
        end else if (div_clr[d]) begin
          div[d] <= {div[d][fps_pkg::DIV_WIDTH-1:4], fps_pkg::DIV_LOW_CLEAR};
        end else begin
          div[d] <= div[d] + 1'b1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Serial transfer on the P0.1 pin
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      ser_is_in <= 1'b0;
      ser_addr <= 7'h00;
    end else if (take && ((op == fps_pkg::OP_SOP) || (op == fps_pkg::OP_SIP))) begin
      ser_is_in <= (op == fps_pkg::OP_SIP);
      ser_addr <= OPCODE_I[6:0];
    end
  end

  fps_serial_shifter fps_serial_shifter_inst (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .start_i(take && ((op == fps_pkg::OP_SOP) || (op == fps_pkg::OP_SIP))),
    .dir_in_i(op == fps_pkg::OP_SIP),
    .tx_byte_i({RAM_RDATA_I, ACC_O}),
    .pin_i(SER_PIN_I),
    .pin_o(SER_PIN_O),
    .pin_oe_o(SER_PIN_OE_O),
    .busy_o(ser_busy),
    .done_o(ser_done),
    .rx_byte_o(ser_rx)
  );

  // ==========================================================
  // AXI4-Lite slave
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_take;
  logic [2:0] status;
  logic [2:0] mask;
  logic [2:0] events;

  assign S_AXI_AWREADY_O = !aw_hold && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = !w_hold && !S_AXI_BVALID_O;
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
  assign wr_fire = aw_hold && w_hold;
  assign rd_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

  // Address and data are taken in either order, then answered together
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= fps_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_hold <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= fps_mapped(aw_addr) ? fps_pkg::RESP_OKAY : fps_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // Writable control and mask; only byte lane 0 carries bits
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_en <= fps_pkg::CTRL_EN_RST;
      mask <= fps_pkg::MASK_RST;
    end else if (wr_fire && w_strb[0]) begin
      if (aw_addr == fps_pkg::REG_CTRL) ctrl_en <= w_data[0];
      if (aw_addr == fps_pkg::REG_MASK) mask <= w_data[2:0];
    end
  end

  // Sticky events; a read clears, but an event in that cycle is kept
  assign events = {|PORT_EVENT_I, ser_done && ser_is_in, ser_done && !ser_is_in};
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      status <= fps_pkg::STATUS_RST;
    end else if (rd_take && (S_AXI_ARADDR_I == fps_pkg::REG_STATUS)) begin
      status <= events;
    end else begin
      status <= status | events;
    end
  end

  assign IRQ_O = |(status & mask);

  // Read answer one cycle after the address is taken
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= fps_pkg::RESP_OKAY;
    end else if (rd_take) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O <= fps_mapped(S_AXI_ARADDR_I) ? fps_pkg::RESP_OKAY : fps_pkg::RESP_SLVERR;
      unique case (S_AXI_ARADDR_I)
        fps_pkg::REG_STATUS: S_AXI_RDATA_O <= {29'h0, status};
        fps_pkg::REG_MASK: S_AXI_RDATA_O <= {29'h0, mask};
        fps_pkg::REG_CTRL: S_AXI_RDATA_O <= {31'h0, ctrl_en};
        fps_pkg::REG_STATE: S_AXI_RDATA_O <= {12'h0, PORT_STATUS_O, 2'h0, ser_busy,
                                               ZERO_FLAG_O, ACC_O};
        default: S_AXI_RDATA_O <= 32'h0000_0000;
      endcase
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  evf_copy_a: assert property (take && op == fps_pkg::OP_EVF_HI |=>
      ACC_O == $past(EVENT_FLAGS_I[7:4]) && RAM_WE_O && RAM_WDATA_O == ACC_O &&
      ZERO_FLAG_O == (ACC_O == 4'h0)) else $error("event flag copy wrong");
  hef_load_a: assert property (take && op == fps_pkg::OP_HEF |=>
      ENABLES_O.hold_release_enables == $past(OPCODE_I[7:0]))
    else $error("hold release enables not loaded");
  hold_release_enable_port2_bit_a: assert property (take && op == fps_pkg::OP_HOLD_RELEASE_ENABLE_PORT2 |=>
      ENABLES_O.hold_release_enable_port2 == $past(OPCODE_I[0]) &&
      $stable(ENABLES_O.hold_release_enables)) else $error("port2 enable wrong");
  ief_load_a: assert property (take && op == fps_pkg::OP_IEF |=>
      ENABLES_O.interrupt_enables == $past(OPCODE_I[7:0]))
    else $error("interrupt enables not loaded");
  secondary_port_enables_load_a: assert property (take && op == fps_pkg::OP_SECONDARY_PORT_ENABLES |=>
      ENABLES_O.secondary_port_enables == $past(OPCODE_I[3:2]))
    else $error("secondary port enables wrong");
  sef_load_a: assert property (take && op == fps_pkg::OP_SEF |=>
      ENABLES_O.stop_wake_enables == $past(OPCODE_I[7:0]))
    else $error("stop wake enables not loaded");
  psr_read_a: assert property (take && op == fps_pkg::OP_PSR_RD1 |=>
      ACC_O == $past(psr[1]) && RAM_WADDR_O == $past(OPCODE_I[6:0]))
    else $error("port status read wrong");
  psr_clear_a: assert property (psr_clr[2] |=>
      psr[2] == $past(PORT_EVENT_I[11:8])) else $error("port status not cleared");
  div_clear_a: assert property (div_clr[0] |=>
      div[0][3:0] == 4'h0 && div[0][14:4] == $past(div[0][14:4]))
    else $error("divider clear wrong");
  sop_drive_a: assert property (take && op == fps_pkg::OP_SOP |=>
      SER_PIN_OE_O && SER_PIN_O == $past(RAM_RDATA_I[3]) ##1 SER_PIN_OE_O[*8])
    else $error("serial out not driven");
  sip_store_a: assert property (ser_done && ser_is_in |=>
      RAM_WE_O && RAM_WDATA_O == $past(ser_rx[7:4]) && ACC_O == $past(ser_rx[3:0]))
    else $error("serial in not stored");
  zf_keep_a: assert property (take && !ld && !(ser_done && ser_is_in) |=>
      $stable(ZERO_FLAG_O) && $stable(ACC_O)) else $error("zero flag disturbed");
  busy_stall_a: assert property (take && op == fps_pkg::OP_SIP |=>
      !OPCODE_READY_O ##[1:100] ser_done) else $error("serial transfer never ends");

  sop_run_c: cover property (take && op == fps_pkg::OP_SOP ##[1:100] ser_done);
  sip_run_c: cover property (take && op == fps_pkg::OP_SIP ##[1:100] ser_done);
  irq_read_c: cover property (IRQ_O ##[1:20] (rd_take && S_AXI_ARADDR_I == fps_pkg::REG_STATUS));
  psr_race_c: cover property (psr_clr[0] && |PORT_EVENT_I[3:0]);

endmodule : fps_flag_port_decoder

/* tb/fps_bench.sv */
// Bench for the flag, port-status and serial opcode decoder.
// Drives opcodes, port events, the pin and AXI4-Lite from one clock.
`timescale 1ns/1ps
module flag_port_serial_op_decoder_bench;
  logic SYS_CLK_I = 0, SYS_RST_I = 1, OPCODE_VALID_I = 0, SER_PIN_I = 0;
  logic OPCODE_READY_O, RAM_WE_O, ZERO_FLAG_O, SER_PIN_O, SER_PIN_OE_O, IRQ_O;
  logic S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
  logic S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0, S_AXI_AWREADY_O;
  logic S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O, both;
  logic [15:0] OPCODE_I = 0;
  logic [7:0] EVENT_FLAGS_I = 8'h50, S_AXI_AWADDR_I = 0, S_AXI_ARADDR_I = 0;
  logic [7:0] tx = 8'hA5, rx = 8'h3C;
  logic [11:0] PORT_EVENT_I = 0, PORT_STATUS_O;
  logic [6:0] RAM_RADDR_O, RAM_WADDR_O;
  logic [3:0] RAM_RDATA_I = 4'hA, S_AXI_WSTRB_I = 4'hF, ACC_O, RAM_WDATA_O;
  logic [31:0] S_AXI_WDATA_I = 0, S_AXI_RDATA_O, rd;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
  logic [fps_pkg::DIV_WIDTH-1:0] DIV0_O, DIV1_O;
  fps_pkg::fps_enables_t ENABLES_O;
  int bad_count = 0, checks_done = 0, i;
  fps_flag_port_decoder fps_flag_port_decoder_inst (.*);
  // Slave takes address and data together while idle
  assign both = S_AXI_AWREADY_O & S_AXI_WREADY_O;
  always #5 SYS_CLK_I = ~SYS_CLK_I;
  // ==========================================================
  // Compare and verdict
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // Bounded wait; returns at a falling edge with the signal high
  task automatic wt(ref logic s);
    int n = 0;
    do begin
      @(negedge SYS_CLK_I);
      n++;
      if (n > 300) bad_count++;
      if (n > 300) test_done;
    end while (s !== 1'b1);
  endtask : wt
  // ==========================================================
  // Access tasks
  task automatic op(input logic [15:0] c);
    @(posedge SYS_CLK_I);
    OPCODE_I <= c;
    OPCODE_VALID_I <= 1;
    wt(OPCODE_READY_O);
    @(posedge SYS_CLK_I);
    OPCODE_VALID_I <= 0;
    repeat (2) @(negedge SYS_CLK_I);
  endtask : op
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1;
    S_AXI_WVALID_I <= 1;
    S_AXI_BREADY_I <= 1;
    wt(both);
    @(posedge SYS_CLK_I);
    S_AXI_AWVALID_I <= 0;
    S_AXI_WVALID_I <= 0;
    wt(S_AXI_BVALID_O);
    chk(S_AXI_BRESP_O, fps_pkg::RESP_OKAY);
    @(posedge SYS_CLK_I);
    S_AXI_BREADY_I <= 0;
  endtask : wr
  task automatic rdr(input logic [7:0] a, input logic [1:0] r);
    @(posedge SYS_CLK_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1;
    S_AXI_RREADY_I <= 1;
    wt(S_AXI_ARREADY_O);
    @(posedge SYS_CLK_I);
    S_AXI_ARVALID_I <= 0;
    wt(S_AXI_RVALID_O);
    rd = S_AXI_RDATA_O;
    chk(S_AXI_RRESP_O, r);
    @(posedge SYS_CLK_I);
    S_AXI_RREADY_I <= 0;
  endtask : rdr
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge SYS_CLK_I);
    SYS_RST_I <= 0;
    op(16'h5D80);
    chk({ACC_O, ZERO_FLAG_O}, 5'h0A);
    op(16'h5D00);
    chk({ACC_O, ZERO_FLAG_O}, 5'h01);
    // Later single-bit load must not disturb the byte loaded before it
    op(16'h415A);
    op(16'h3101);
    op(16'h51C3);
    op(16'h4309);
    op(16'h3308);
    op(16'h5281);
    chk(ENABLES_O, 31'h2D70_E681);
    chk(ZERO_FLAG_O, 1);
    @(posedge SYS_CLK_I) PORT_EVENT_I <= 12'h9C6;
    @(posedge SYS_CLK_I) PORT_EVENT_I <= 0;
    op(16'h4F00);
    chk(ACC_O, 4'h6);
    op(16'h4F80);
    chk(ACC_O, 4'hC);
    op(16'h5F00);
    chk(ACC_O, 4'h9);
    op(16'h4280);
    chk(PORT_STATUS_O, 12'h906);
    op(16'h42C0);
    chk(PORT_STATUS_O, 12'h006);
    op(16'h4200);
    chk(PORT_STATUS_O, 12'h000);
    op(16'h1700);
    chk(DIV0_O[3:0], 4'h1);
    op(16'h5580);
    chk(DIV1_O[3:0], 4'h1);
    wr(fps_pkg::REG_MASK, 32'h2);
    op(16'h5D80);
    op(16'hAF2B);
    chk(RAM_RADDR_O, 7'h2B);
    // Sample each bit near the middle of its ten cycles
    for (i = 7; i >= 0; i--) begin
      repeat (i == 7 ? 5 : 10) @(negedge SYS_CLK_I);
      chk({SER_PIN_OE_O, SER_PIN_O}, {1'b1, tx[i]});
    end
    wt(OPCODE_READY_O);
    chk({SER_PIN_OE_O, IRQ_O}, 0);
    op(16'h9F11);
    for (i = 7; i >= 0; i--) begin
      @(posedge SYS_CLK_I) SER_PIN_I <= rx[i];
      repeat (9) @(posedge SYS_CLK_I);
    end
    wt(RAM_WE_O);
    chk({RAM_WADDR_O, RAM_WDATA_O, ACC_O, ZERO_FLAG_O}, 16'h2278);
    chk(IRQ_O, 1);
    rdr(fps_pkg::REG_STATUS, fps_pkg::RESP_OKAY);
    chk(rd, 32'h7);
    repeat (2) @(negedge SYS_CLK_I);
    chk(IRQ_O, 0);
    rdr(fps_pkg::REG_MASK, fps_pkg::RESP_OKAY);
    chk(rd, 32'h2);
    rdr(8'h10, fps_pkg::RESP_SLVERR);
    chk(rd, 0);
    wr(fps_pkg::REG_CTRL, 0);
    chk(OPCODE_READY_O, 0);
    test_done;
  end
endmodule : flag_port_serial_op_decoder_bench
